// *** rtl/fca_flash_seq.sv ***
// Function
// - State readable in status, access-status registers
// - Command lock is OR of six errors
// - Entry value selects read, code, data mode
// - Each mode permits its own command set
// - Unacknowledged command locks; ignored one does nothing
// - P/E busy: suspend ready, only suspend and stop taken
// - Special ops busy: all P/E commands rejected
// - Suspending takes only stop; suspended accepts resume
// - Erase suspended accepts programming elsewhere
// - No programming into the erase-suspended block
// - Check or lock read keeps suspend flags
// - Locked rejects work; ready suspend ignored
// - Forced stop busy rejects all but stop
// - Idle ready; suspend ignored; DMA data only
// - Ready rising raises completion interrupt pulse
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module fca_flash_seq
    import fca_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        array_fault,
    output logic             sequencer_done_interrupt
);

    fca_state_e       state_reg;
    fca_state_e       ret_reg;
    fca_state_e       start_state;
    logic [15:0]      cnt_reg;
    logic [15:0]      saved_cnt_reg;
    logic [7:0]       op_reg;
    logic [7:0]       saved_op_reg;
    logic [7:0]       blk_reg;
    logic             psusp_reg;
    logic             esusp_reg;
    logic [ERR_W-1:0] err_reg;
    logic [ERR_W-1:0] err_set;
    logic             err_clr;
    logic [15:0]      pe_mode_entry_reg;
    logic [15:0]      optime_reg;
    logic             prev_rdy_reg;
    logic             ready_w;
    logic             suspend_ready_flag_w;
    logic             lock_w;
    logic             busy_w;
    logic             wr_go;
    logic             cmd_wr;
    logic             cmd_acc;
    logic             done_w;
    logic             fault_done;
    logic             stop_done;
    logic [7:0]       cmd_op;
    logic [7:0]       cmd_blk;
    logic [31:0]      sequencer_status_reg;
    logic [31:0]      access_status_reg;
    logic [31:0]      rd_word;

    fca_cmd_if cif ();

    fca_accept u_accept
    (
        .cif (cif.chk)
    );

    assign cmd_op          = avs_writedata[7:0];
    assign cmd_blk         = avs_writedata[15:8];
    assign wr_go           = avs_write && !avs_waitrequest;
    assign cmd_wr          = wr_go && avs_address == OFS_CMD;
    assign cmd_acc         = cmd_wr && cif.verdict == V_ACCEPT;
    assign ready_w         = fca_ready(state_reg);
    assign busy_w          = !ready_w;
    assign lock_w          = |err_reg;
    assign suspend_ready_flag_w        = state_reg == S_PE_BUSY && !lock_w;
    assign done_w          = busy_w && cnt_reg == 16'h0000 && !cmd_acc;
    assign stop_done       = done_w && state_reg == S_STOPPING;
    assign fault_done      = done_w && array_fault
                             && !(state_reg inside {S_SUSPENDING, S_STOPPING});

    assign cif.state      = state_reg;
    assign cif.locked     = lock_w;
    assign cif.mode       = pe_mode_entry_reg;
    assign cif.opcode     = cmd_op;
    assign cif.same_block = cmd_blk == blk_reg;

    // Register file seen by software
    always_comb
    begin
        sequencer_status_reg = '0;
        sequencer_status_reg[ST_READY] = ready_w;
        sequencer_status_reg[ST_SUSPEND_READY_FLAG] = suspend_ready_flag_w;
        sequencer_status_reg[ST_ESUSP] = esusp_reg;
        sequencer_status_reg[ST_PSUSP] = psusp_reg;
        sequencer_status_reg[ERR_W-1:0] = err_reg;
        access_status_reg = '0;
        access_status_reg[AS_LOCK] = lock_w;
    end

    always_comb
    begin
        case (avs_address)
            OFS_ENTRY:  rd_word = {16'h0000, pe_mode_entry_reg};
            OFS_STAT:   rd_word = sequencer_status_reg;
            OFS_ASTAT:  rd_word = access_status_reg;
            OFS_OPTIME: rd_word = {16'h0000, optime_reg};
            default:    rd_word = 32'h0000_0000;
        endcase
    end

    // One wait state per access keeps read data a flop output
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end
        else if ((avs_read || avs_write) && avs_waitrequest)
        begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= avs_read ? rd_word : 32'h0000_0000;
        end
        else
        begin
            avs_waitrequest <= 1'b1;
        end
    end

    // Mode entry accepts only the three legal codes
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pe_mode_entry_reg <= MODE_READ;
            optime_reg        <= OPTIME_RST;
        end
        else if (wr_go)
        begin
            if (avs_address == OFS_ENTRY && avs_writedata[15:0] inside
                {MODE_READ, MODE_CODE, MODE_DATA})
                pe_mode_entry_reg <= avs_writedata[15:0];
            if (avs_address == OFS_OPTIME)
                optime_reg <= avs_writedata[15:0];
        end
    end

    always_comb
    begin
        case (cmd_op)
            OP_PROG:
                start_state = (state_reg == S_ERASE_SUSP) ? S_PROG_IN_ESUSP : S_PE_BUSY;
            OP_DMA:
                start_state = (state_reg == S_ERASE_SUSP) ? S_PROG_IN_ESUSP : S_SPECIAL;
            OP_ERASE:
                start_state = S_PE_BUSY;
            OP_CHECK:
                start_state = S_CHECK;
            default:
                start_state = S_SPECIAL;
        endcase
    end

    // Sequencer; ret_reg holds where a finished job goes back to
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state_reg     <= S_IDLE;
            ret_reg       <= S_IDLE;
            cnt_reg       <= 16'h0000;
            saved_cnt_reg <= 16'h0000;
            op_reg        <= 8'h00;
            saved_op_reg  <= 8'h00;
            blk_reg       <= 8'h00;
            psusp_reg     <= 1'b0;
            esusp_reg     <= 1'b0;
        end
        else if (cmd_acc)
        begin
            case (cmd_op)
                OP_SUSPEND:
                begin
                    saved_cnt_reg <= cnt_reg;
                    saved_op_reg  <= op_reg;
                    cnt_reg       <= SUSP_CYCLES;
                    state_reg     <= S_SUSPENDING;
                end
                OP_RESUME:
                begin
                    cnt_reg   <= saved_cnt_reg;
                    op_reg    <= saved_op_reg;
                    ret_reg   <= S_IDLE;
                    state_reg <= S_PE_BUSY;
                    psusp_reg <= 1'b0;
                    esusp_reg <= 1'b0;
                end
                OP_STOP:
                begin
                    cnt_reg   <= STOP_CYCLES;
                    state_reg <= S_STOPPING;
                    psusp_reg <= 1'b0;
                    esusp_reg <= 1'b0;
                end
                OP_CLEAR:
                begin
                    cnt_reg <= cnt_reg;
                end
                default:
                begin
                    cnt_reg   <= optime_reg;
                    op_reg    <= cmd_op;
                    ret_reg   <= state_reg;
                    state_reg <= start_state;
                    if (cmd_op == OP_ERASE)
                        blk_reg <= cmd_blk;
                end
            endcase
        end
        else if (busy_w && cnt_reg != 16'h0000)
        begin
            cnt_reg <= cnt_reg - 16'h0001;
        end
        else if (busy_w)
        begin
            case (state_reg)
                S_SUSPENDING:
                begin
                    if (saved_op_reg == OP_ERASE)
                    begin
                        esusp_reg <= 1'b1;
                        state_reg <= S_ERASE_SUSP;
                    end
                    else
                    begin
                        psusp_reg <= 1'b1;
                        state_reg <= S_PROG_SUSP;
                    end
                end
                S_STOPPING:
                begin
                    ret_reg   <= S_IDLE;
                    state_reg <= S_IDLE;
                end
                default:
                begin
                    state_reg <= ret_reg;
                end
            endcase
        end
    end

    // A new error wins over a clear in the same cycle
    always_comb
    begin
        err_set = '0;
        if (cmd_wr && cif.verdict == V_REJECT)
            err_set[ERR_ILLEGAL] = 1'b1;
        if (fault_done)
            err_set = err_set | fca_fault_flag(op_reg);
        err_clr = (cmd_acc && cmd_op == OP_CLEAR) || stop_done;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            err_reg <= '0;
        else
            err_reg <= (err_reg & ~{ERR_W{err_clr}}) | err_set;
    end

    // Reset value 1 so leaving reset gives no spurious pulse
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            prev_rdy_reg             <= 1'b1;
            sequencer_done_interrupt <= 1'b0;
        end
        else
        begin
            prev_rdy_reg             <= ready_w;
            sequencer_done_interrupt <= ready_w && !prev_rdy_reg;
        end
    end

    sequence s_suspending;
        (state_reg == S_SUSPENDING)[*8] ##1 (state_reg == S_SUSPENDING);
    endsequence

    sequence s_suspended;
        ready_w && (psusp_reg || esusp_reg);
    endsequence

    sequence s_stopping;
        (state_reg == S_STOPPING && !ready_w)[*5];
    endsequence

    property p_lock_read;
        @(posedge mclk) disable iff (rst)
        (avs_read && avs_waitrequest && avs_address == OFS_ASTAT)
        |=> avs_readdata[AS_LOCK] == $past(lock_w);
    endproperty
    a_lock_read: assert property (p_lock_read)
        else $error("lock bit read does not match error flags");

    property p_read_mode;
        @(posedge mclk) disable iff (rst)
        (cmd_wr && pe_mode_entry_reg == MODE_READ) |=> err_reg[ERR_ILLEGAL];
    endproperty
    a_read_mode: assert property (p_read_mode)
        else $error("command in read mode not flagged");

    property p_busy_reject;
        @(posedge mclk) disable iff (rst)
        (cmd_wr && state_reg == S_PE_BUSY && cmd_op == OP_ERASE && cnt_reg != 16'h0000)
        |=> err_reg[ERR_ILLEGAL] && state_reg == $past(state_reg);
    endproperty
    a_busy_reject: assert property (p_busy_reject)
        else $error("erase during busy not rejected");

    property p_suspend;
        @(posedge mclk) disable iff (rst)
        (cmd_acc && cmd_op == OP_SUSPEND) |=> s_suspending ##1 s_suspended;
    endproperty
    a_suspend: assert property (p_suspend)
        else $error("suspend did not complete on time");

    property p_same_block;
        @(posedge mclk) disable iff (rst)
        (cmd_wr && state_reg == S_ERASE_SUSP && cmd_op == OP_PROG
         && cmd_blk == blk_reg) |=> err_reg[ERR_ILLEGAL] && esusp_reg;
    endproperty
    a_same_block: assert property (p_same_block)
        else $error("programming of suspended block accepted");

    property p_stop;
        @(posedge mclk) disable iff (rst)
        (cmd_acc && cmd_op == OP_STOP) |=> s_stopping ##1 (state_reg == S_IDLE && err_reg == '0);
    endproperty
    a_stop: assert property (p_stop)
        else $error("forced stop did not finish clean");

    property p_idle_suspend;
        @(posedge mclk) disable iff (rst)
        (cmd_wr && state_reg == S_IDLE && cmd_op == OP_SUSPEND
         && pe_mode_entry_reg != MODE_READ)
        |=> state_reg == S_IDLE && $stable(err_reg);
    endproperty
    a_idle_suspend: assert property (p_idle_suspend)
        else $error("suspend in idle was not ignored");

    property p_done_irq;
        @(posedge mclk) disable iff (rst)
        $rose(ready_w) |=> sequencer_done_interrupt ##1 !sequencer_done_interrupt;
    endproperty
    a_done_irq: assert property (p_done_irq)
        else $error("completion interrupt missing");

    property p_clear;
        @(posedge mclk) disable iff (rst)
        (cmd_acc && cmd_op == OP_CLEAR) |=> err_reg == '0 && !lock_w;
    endproperty
    a_clear: assert property (p_clear)
        else $error("status clear left errors set");

endmodule // fca_flash_seq

// *** rtl/fca_pkg.sv ***
package fca_pkg;

    localparam logic [4:0] OFS_ENTRY  = 5'h00;
    localparam logic [4:0] OFS_CMD    = 5'h04;
    localparam logic [4:0] OFS_STAT   = 5'h08;
    localparam logic [4:0] OFS_ASTAT  = 5'h0C;
    localparam logic [4:0] OFS_OPTIME = 5'h10;

    localparam logic [15:0] MODE_READ = 16'h0000;
    localparam logic [15:0] MODE_CODE = 16'h0001;
    localparam logic [15:0] MODE_DATA = 16'h0080;

    localparam logic [7:0] OP_PROG     = 8'hE8;
    localparam logic [7:0] OP_DMA      = 8'hEA;
    localparam logic [7:0] OP_ERASE    = 8'h20;
    localparam logic [7:0] OP_SUSPEND  = 8'hB0;
    localparam logic [7:0] OP_RESUME   = 8'hD0;
    localparam logic [7:0] OP_CLEAR    = 8'h50;
    localparam logic [7:0] OP_STOP     = 8'hB3;
    localparam logic [7:0] OP_CHECK    = 8'h71;
    localparam logic [7:0] OP_CONFIG   = 8'h40;
    localparam logic [7:0] OP_LOCKPROG = 8'h77;
    localparam logic [7:0] OP_OTP      = 8'h45;

    localparam int ST_READY  = 15;
    localparam int ST_SUSPEND_READY_FLAG = 14;
    localparam int ST_ESUSP  = 13;
    localparam int ST_PSUSP  = 12;
    localparam int AS_LOCK   = 0;

    localparam int ERR_W       = 6;
    localparam int ERR_OTP     = 0;
    localparam int ERR_ILLEGAL = 1;
    localparam int ERR_ERASE   = 2;
    localparam int ERR_PROG    = 3;
    localparam int ERR_CONFIG  = 4;
    localparam int ERR_TABLE   = 5;

    localparam logic [15:0] OPTIME_RST  = 16'h0040;
    localparam logic [15:0] SUSP_CYCLES = 16'h0008;
    localparam logic [15:0] STOP_CYCLES = 16'h0004;

    typedef enum logic [3:0] {
        S_IDLE, S_PE_BUSY, S_SPECIAL, S_SUSPENDING, S_PROG_SUSP,
        S_ERASE_SUSP, S_PROG_IN_ESUSP, S_CHECK, S_STOPPING
    } fca_state_e;

    typedef enum logic [1:0] {V_ACCEPT, V_IGNORE, V_REJECT} fca_verdict_e;

    function automatic logic fca_ready(input fca_state_e s);
        return s inside {S_IDLE, S_PROG_SUSP, S_ERASE_SUSP};
    endfunction

    function automatic logic [ERR_W-1:0] fca_fault_flag(input logic [7:0] op);
        logic [ERR_W-1:0] f;
        f = '0;
        case (op)
            OP_ERASE:  f[ERR_ERASE] = 1'b1;
            OP_CONFIG: f[ERR_CONFIG] = 1'b1;
            OP_OTP:    f[ERR_OTP] = 1'b1;
            OP_CHECK:  f[ERR_TABLE] = 1'b1;
            default:   f[ERR_PROG] = 1'b1;
        endcase
        return f;
    endfunction

endpackage

// *** rtl/fca_cmd_if.sv ***
`timescale 1ns/1ps
interface fca_cmd_if;
    import fca_pkg::*;
    fca_state_e   state;
    logic         locked;
    logic [15:0]  mode;
    logic [7:0]   opcode;
    logic         same_block;
    fca_verdict_e verdict;
    modport seq (output state, locked, mode, opcode, same_block, input verdict);
    modport chk (input state, locked, mode, opcode, same_block, output verdict);
endinterface

// *** rtl/fca_accept.sv ***
`timescale 1ns/1ps
module fca_accept
    import fca_pkg::*;
(
    fca_cmd_if.chk cif
);

    logic rdy;
    logic allowed;
    logic [7:0] op;

    always_comb
    begin
        op  = cif.opcode;
        rdy = fca_ready(cif.state);
        case (cif.mode)
            MODE_CODE: allowed = op inside {OP_PROG, OP_ERASE, OP_SUSPEND, OP_RESUME,
                                            OP_CLEAR, OP_STOP, OP_LOCKPROG, OP_CHECK};
            MODE_DATA: allowed = op inside {OP_PROG, OP_DMA, OP_ERASE, OP_SUSPEND,
                                            OP_RESUME, OP_CLEAR, OP_STOP, OP_CHECK,
                                            OP_CONFIG, OP_OTP};
            default:   allowed = 1'b0;
        endcase
    end

    always_comb
    begin
        cif.verdict = V_REJECT;
        if (!allowed)
            cif.verdict = V_REJECT;
        else if (op == OP_STOP)
            cif.verdict = V_ACCEPT;
        else if (op == OP_CLEAR)
            cif.verdict = rdy ? V_ACCEPT : V_REJECT;
        else if (cif.locked)
            cif.verdict = (op == OP_SUSPEND && rdy) ? V_IGNORE : V_REJECT;
        else
        begin
            case (cif.state)
                S_IDLE:
                    if (op == OP_SUSPEND)
                        cif.verdict = V_IGNORE;
                    else if (op != OP_RESUME)
                        cif.verdict = V_ACCEPT;
                S_PE_BUSY:
                    if (op == OP_SUSPEND)
                        cif.verdict = V_ACCEPT;
                S_PROG_SUSP:
                    if (op == OP_RESUME || op == OP_CHECK)
                        cif.verdict = V_ACCEPT;
                S_ERASE_SUSP:
                    if (op == OP_RESUME || op == OP_CHECK)
                        cif.verdict = V_ACCEPT;
                    else if ((op == OP_PROG || op == OP_DMA) && !cif.same_block)
                        cif.verdict = V_ACCEPT;
                default:
                    cif.verdict = V_REJECT;
            endcase
        end
    end

endmodule // fca_accept

// *** tb/fca_host_model.sv ***
`timescale 1ns/1ps
module fca_host_model
    import fca_pkg::*;
(
    input  wire logic        mclk,
    output logic      [4:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    initial
    begin
        avs_address   = 5'h00;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_writedata = 32'h0;
    end

    // Held until waitrequest is seen low, for at most 32 cycles; no fixed latency is assumed
    task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic ok);
        int n;
        ok = 1'b0;
        q  = 32'h0;
        @(posedge mclk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        for (n = 0; n < 32 && !ok; n++)
        begin
            @(posedge mclk);
            if (avs_waitrequest === 1'b0)
            begin
                ok = 1'b1;
                q  = avs_readdata;
            end
        end
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
endmodule // fca_host_model

// *** tb/flash_command_acceptance_fsm_tb.sv ***
`timescale 1ns/1ps
module flash_command_acceptance_fsm_tb
    import fca_pkg::*;
;
    logic        mclk;
    logic        rst;
    logic        array_fault;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        sequencer_done_interrupt;
    logic [31:0] q;
    int          err_count;
    int          samples_checked;
    int          irq_count;
    int          n;
    logic [15:0] modes [3] = '{MODE_READ, MODE_CODE, MODE_DATA};
    logic [7:0]  ops [11] = '{OP_PROG, OP_DMA, OP_ERASE, OP_SUSPEND, OP_RESUME, OP_CLEAR,
                              OP_STOP, OP_CHECK, OP_CONFIG, OP_LOCKPROG, OP_OTP};

    always #20 mclk = ~mclk;

    always @(posedge mclk)
    begin
        if (sequencer_done_interrupt === 1'b1)
            irq_count <= irq_count + 1;
    end

    fca_flash_seq u_dut (
        .mclk                     (mclk),
        .rst                      (rst),
        .avs_address              (avs_address),
        .avs_read                 (avs_read),
        .avs_write                (avs_write),
        .avs_writedata            (avs_writedata),
        .avs_readdata             (avs_readdata),
        .avs_waitrequest          (avs_waitrequest),
        .array_fault              (array_fault),
        .sequencer_done_interrupt (sequencer_done_interrupt)
    );

    fca_host_model u_host (
        .mclk            (mclk),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest)
    );

    task automatic print_verdict();
        if (err_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input logic [31:0] mask, input string m);
        samples_checked++;
        if ((got & mask) !== (exp & mask))
        begin
            err_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        logic ok;
        u_host.xfer(wr, a, d, r, ok);
        if (ok !== 1'b1)
        begin
            err_count++;
            $display("mismatch at %0t: bus timeout", $time);
            print_verdict();
        end
    endtask

    task automatic cmd(input logic [7:0] op, input logic [7:0] blk);
        logic [31:0] r;
        bus(1'b1, OFS_CMD, {16'h0, blk, op}, r);
    endtask

    // Flags [15:12] are ready, suspend ready, erase and program suspended
    task automatic st(input logic [3:0] f, input logic [3:0] fm, input logic [5:0] e,
                      input string m);
        logic [31:0] r;
        bus(1'b0, OFS_STAT, 32'h0, r);
        chk(r, {16'h0, f, 6'h0, e}, {16'h0, fm, 6'h0, 6'h3F}, m);
        bus(1'b0, OFS_ASTAT, 32'h0, r);
        chk(r, {31'h0, |e}, 32'h1, m);
    endtask

    task automatic wait_ready();
        logic [31:0] r;
        r = 32'h0;
        for (int k = 0; k < 100 && r[15] !== 1'b1; k++)
            bus(1'b0, OFS_STAT, 32'h0, r);
        if (r[15] !== 1'b1)
        begin
            err_count++;
            $display("mismatch at %0t: ready never returned", $time);
            print_verdict();
        end
    endtask

    function automatic logic refused(input int m, input logic [7:0] op);
        if (m == 0)
            return 1'b1;
        case (op)
            OP_RESUME:                 return 1'b1;
            OP_DMA, OP_CONFIG, OP_OTP: return m == 1;
            OP_LOCKPROG:               return m == 2;
            default:                   return 1'b0;
        endcase
    endfunction

    initial
    begin
        mclk = 1'b0;
        rst = 1'b1;
        array_fault = 1'b0;
        err_count = 0;
        samples_checked = 0;
        irq_count = 0;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        bus(1'b0, OFS_ENTRY, 32'h0, q);
        chk(q, 32'h0, 32'hFFFF, "entry reset");
        bus(1'b0, OFS_OPTIME, 32'h0, q);
        chk(q, {16'h0, OPTIME_RST}, 32'hFFFF, "op time reset");
        st(4'h8, 4'hF, 6'h00, "idle after reset");
        bus(1'b1, OFS_ENTRY, 32'h0000_0002, q);
        bus(1'b0, OFS_ENTRY, 32'h0, q);
        chk(q, 32'h0, 32'hFFFF, "bad entry value taken");
        bus(1'b1, OFS_OPTIME, 32'h0000_000F, q);
        // Every command in every mode, from idle
        for (int m = 0; m < 3; m++)
        begin
            for (int i = 0; i < 11; i++)
            begin
                bus(1'b1, OFS_ENTRY, {16'h0, modes[m]}, q);
                cmd(ops[i], 8'h01);
                wait_ready();
                st(4'h8, 4'hF, {4'h0, refused(m, ops[i]), 1'b0}, "mode set");
                bus(1'b1, OFS_ENTRY, {16'h0, MODE_CODE}, q);
                cmd(OP_CLEAR, 8'h00);
            end
        end
        cmd(OP_RESUME, 8'h00);
        cmd(OP_SUSPEND, 8'h00);
        st(4'h8, 4'hF, 6'h02, "locked ready suspend");
        cmd(OP_CLEAR, 8'h00);
        n = irq_count;
        cmd(OP_PROG, 8'h01);
        st(4'h4, 4'hF, 6'h00, "program busy");
        cmd(OP_ERASE, 8'h02);
        st(4'h0, 4'hB, 6'h02, "erase while busy");
        wait_ready();
        repeat (2) @(posedge mclk);
        chk(32'(irq_count - n), 32'h1, 32'hFFFF_FFFF, "done pulse count");
        cmd(OP_CLEAR, 8'h00);
        // Erase suspend with programming to other blocks
        bus(1'b1, OFS_OPTIME, 32'h0000_0030, q);
        cmd(OP_ERASE, 8'h02);
        cmd(OP_SUSPEND, 8'h00);
        st(4'h0, 4'hF, 6'h00, "suspending");
        wait_ready();
        st(4'hA, 4'hF, 6'h00, "erase suspended");
        cmd(OP_PROG, 8'h02);
        st(4'hA, 4'hF, 6'h02, "same block program");
        cmd(OP_CLEAR, 8'h00);
        cmd(OP_PROG, 8'h03);
        st(4'h2, 4'hF, 6'h00, "program in erase suspend");
        cmd(OP_SUSPEND, 8'h00);
        st(4'h2, 4'hF, 6'h02, "suspend in erase suspend");
        wait_ready();
        cmd(OP_CLEAR, 8'h00);
        cmd(OP_RESUME, 8'h00);
        st(4'h4, 4'hF, 6'h00, "erase resumed");
        wait_ready();
        st(4'h8, 4'hF, 6'h00, "idle after erase");
        // Program suspend, then a lock-bit read inside it
        cmd(OP_PROG, 8'h01);
        cmd(OP_SUSPEND, 8'h00);
        wait_ready();
        st(4'h9, 4'hF, 6'h00, "program suspended");
        cmd(OP_CHECK, 8'h01);
        st(4'h1, 4'hF, 6'h00, "lock read in suspend");
        wait_ready();
        cmd(OP_RESUME, 8'h00);
        wait_ready();
        st(4'h8, 4'hF, 6'h00, "idle after resume");
        // Data mode: DMA busy state and failing jobs
        bus(1'b1, OFS_ENTRY, {16'h0, MODE_DATA}, q);
        cmd(OP_DMA, 8'h01);
        st(4'h0, 4'hF, 6'h00, "dma busy");
        cmd(OP_SUSPEND, 8'h00);
        st(4'h0, 4'hF, 6'h02, "suspend during dma");
        wait_ready();
        cmd(OP_CLEAR, 8'h00);
        array_fault <= 1'b1;
        cmd(OP_CHECK, 8'h01);
        wait_ready();
        st(4'h8, 4'hF, 6'h20, "blank check fault");
        cmd(OP_CLEAR, 8'h00);
        cmd(OP_PROG, 8'h01);
        wait_ready();
        array_fault <= 1'b0;
        st(4'h8, 4'hF, 6'h08, "program fault");
        cmd(OP_CLEAR, 8'h00);
        // Forced stop mid-job, and as an unlock
        cmd(OP_PROG, 8'h01);
        cmd(OP_STOP, 8'h00);
        st(4'h0, 4'hF, 6'h00, "stopping");
        wait_ready();
        cmd(OP_RESUME, 8'h00);
        cmd(OP_STOP, 8'h00);
        wait_ready();
        st(4'h8, 4'hF, 6'h00, "unlocked by stop");
        print_verdict();
    end
endmodule // flash_command_acceptance_fsm_tb
